// [hw/cabo_core.sv]
// Execution datapath for literal/file add and AND plus bit clear, set and test-skip.
// Assumes the decode stage presents one decoded instruction per cycle, synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none

module cabo_core (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire cabo_pkg::cabo_instr_s instr,
    output logic [7:0] acc_out,
    output cabo_pkg::cabo_status_s status_out,
    output cabo_pkg::cabo_fwr_s file_wr_out,
    output logic op_done,
    output logic nop_slot
);
    import cabo_pkg::*;

    logic [DATA_W-1:0] file_mem [FILE_DEPTH];
    logic [DATA_W-1:0] acc_reg, acc_next;
    cabo_status_s status_reg, status_next;
    cabo_fwr_s fwr_reg, fwr_next;
    logic done_reg, done_next;
    logic skip_reg, skip_next;
    logic exec;
    logic [DATA_W-1:0] file_byte;
    logic [DATA_W-1:0] operand;
    logic [DATA_W:0] sum_w;
    logic [HALF_CARRY_BIT:0] half_w;
    logic [DATA_W-1:0] and_w;
    logic [DATA_W-1:0] bit_mask;

    function automatic logic [DATA_W-1:0] onehot8(input logic [2:0] pos);
        onehot8 = 8'h01 << pos;
    endfunction

    function automatic logic is_literal(input cabo_op_e op);
        is_literal = (op == CABO_LITERAL_ADD_TO_ACC) || (op == CABO_LITERAL_AND_TO_ACC);
    endfunction

    // Fetched slot behind a taken skip is thrown away, not executed
    assign exec = instr_valid && !skip_reg;
    assign file_byte = file_mem[instr.faddr];
    assign operand = is_literal(instr.op) ? instr.literal : file_byte;
    assign sum_w = {1'b0, acc_reg} + {1'b0, operand};
    assign half_w = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]};
    assign and_w = acc_reg & operand;
    assign bit_mask = onehot8(instr.bitsel);

    always_comb begin
        acc_next = acc_reg;
        status_next = status_reg;
        fwr_next = FWR_RST;
        // Address echoes the presented instruction even with no write; only valid qualifies it
        fwr_next.addr = instr.faddr;
        done_next = 1'b0;
        skip_next = 1'b0;
        if (exec) begin
            done_next = 1'b1;
            unique case (instr.op)
                CABO_NOP: begin
                end
                CABO_LITERAL_ADD_TO_ACC, CABO_FILE_ADD_TO_ACC: begin
                    status_next.carry = sum_w[DATA_W];
                    status_next.half_carry_flag = half_w[HALF_CARRY_BIT];
                    status_next.zero = (sum_w[DATA_W-1:0] == 8'h00);
                    if (instr.op == CABO_FILE_ADD_TO_ACC && instr.dest == DEST_FILE) begin
                        fwr_next.valid = 1'b1;
                        fwr_next.data = sum_w[DATA_W-1:0];
                    end else begin
                        acc_next = sum_w[DATA_W-1:0];
                    end
                end
                CABO_LITERAL_AND_TO_ACC, CABO_FILE_AND_TO_ACC: begin
                    status_next.zero = (and_w == 8'h00);
                    if (instr.op == CABO_FILE_AND_TO_ACC && instr.dest == DEST_FILE) begin
                        fwr_next.valid = 1'b1;
                        fwr_next.data = and_w;
                    end else begin
                        acc_next = and_w;
                    end
                end
                CABO_BIT_CLEAR_OP: begin
                    fwr_next.valid = 1'b1;
                    fwr_next.data = file_byte & ~bit_mask;
                end
                CABO_BIT_SET_OP: begin
                    fwr_next.valid = 1'b1;
                    fwr_next.data = file_byte | bit_mask;
                end
                CABO_BIT_TEST_SKIP_IF_ZERO: begin
                    // Only a clear bit costs the extra cycle
                    skip_next = ((file_byte & bit_mask) == 8'h00);
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_reg <= ACC_RST;
            status_reg <= STATUS_RST;
            fwr_reg <= FWR_RST;
            done_reg <= 1'b0;
            skip_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            status_reg <= status_next;
            fwr_reg <= fwr_next;
            done_reg <= done_next;
            skip_reg <= skip_next;
        end
    end

    // Cleared on reset so bit tests never read unknowns; costs a reset fan-out on 128 bytes
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < FILE_DEPTH; i++) begin
            if (rst) begin
                file_mem[i] <= FILE_RST;
            end else if (fwr_next.valid && fwr_next.addr == FADDR_W'(i)) begin
                file_mem[i] <= fwr_next.data;
            end
        end
    end

    assign acc_out = acc_reg;
    assign status_out = status_reg;
    assign file_wr_out = fwr_reg;
    assign op_done = done_reg;
    assign nop_slot = skip_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_lit_add_result: assert property (exec && instr.op == CABO_LITERAL_ADD_TO_ACC |=>
        acc_reg == 8'($past(acc_reg) + $past(instr.literal)))
        else $error("literal add result wrong");

    a_add_carry_flags: assert property (exec && instr.op == CABO_FILE_ADD_TO_ACC |=>
        status_reg.carry == ((9'($past(acc_reg)) + 9'($past(file_byte))) > 9'h0FF)
        && status_reg.half_carry_flag == ((5'($past(acc_reg[3:0])) + 5'($past(file_byte[3:0]))) > 5'h0F)
        && status_reg.zero == (8'($past(acc_reg) + $past(file_byte)) == 8'h00))
        else $error("add flags wrong");

    a_file_dest_route: assert property (exec && instr.op == CABO_FILE_ADD_TO_ACC && instr.dest |=>
        $stable(acc_reg) && fwr_reg.valid && fwr_reg.addr == $past(instr.faddr)
        && fwr_reg.data == 8'($past(acc_reg) + $past(file_byte)))
        else $error("file destination not honoured");

    a_and_keeps_carry: assert property (exec && (instr.op == CABO_LITERAL_AND_TO_ACC ||
        instr.op == CABO_FILE_AND_TO_ACC) |=> $stable(status_reg.carry) && $stable(status_reg.half_carry_flag))
        else $error("AND touched carry flags");

    a_file_and_acc: assert property (exec && instr.op == CABO_FILE_AND_TO_ACC && !instr.dest |=>
        acc_reg == ($past(acc_reg) & $past(file_byte)) && !fwr_reg.valid)
        else $error("file AND to accumulator wrong");

    a_bit_clear_data: assert property (exec && instr.op == CABO_BIT_CLEAR_OP |=>
        fwr_reg.valid && fwr_reg.data == ($past(file_byte) & ~(8'h01 << $past(instr.bitsel))) && $stable(status_reg))
        else $error("bit clear wrong");

    a_bit_set_data: assert property (exec && instr.op == CABO_BIT_SET_OP |=>
        fwr_reg.valid && fwr_reg.data == ($past(file_byte) | (8'h01 << $past(instr.bitsel))) && $stable(status_reg))
        else $error("bit set wrong");

    a_test_set_noskip: assert property (exec && instr.op == CABO_BIT_TEST_SKIP_IF_ZERO &&
        file_byte[instr.bitsel] |=> !skip_reg && $stable(status_reg))
        else $error("skip taken on set bit");

    a_skip_two_cycles: assert property (exec && instr.op == CABO_BIT_TEST_SKIP_IF_ZERO &&
        !file_byte[instr.bitsel] |=> skip_reg ##1 (!skip_reg && !done_reg && $stable(acc_reg)))
        else $error("taken skip not a two-cycle NOP");

    a_single_cycle_done: assert property (exec && instr.op != CABO_BIT_TEST_SKIP_IF_ZERO |=>
        done_reg && !skip_reg)
        else $error("operation did not complete in one cycle");

    a_file_add_acc: assert property (exec && instr.op == CABO_FILE_ADD_TO_ACC && !instr.dest |=>
        acc_reg == 8'($past(acc_reg) + $past(file_byte))
        && !fwr_reg.valid)
        else $error("file add to accumulator wrong");

    a_lit_and_result: assert property (exec && instr.op == CABO_LITERAL_AND_TO_ACC |=>
        acc_reg == ($past(acc_reg) & $past(instr.literal)) && !fwr_reg.valid
        && status_reg.zero == (($past(acc_reg) & $past(instr.literal)) == 8'h00))
        else $error("literal AND result wrong");

    a_file_and_dest: assert property (exec && instr.op == CABO_FILE_AND_TO_ACC && instr.dest |=>
        $stable(acc_reg) && fwr_reg.valid && fwr_reg.addr == $past(instr.faddr)
        && fwr_reg.data == ($past(acc_reg) & $past(file_byte)))
        else $error("file AND to file register wrong");

    a_test_no_write: assert property (exec && instr.op == CABO_BIT_TEST_SKIP_IF_ZERO |=>
        done_reg && !fwr_reg.valid
        && $stable(acc_reg) && $stable(status_reg))
        else $error("bit test changed state");

    a_idle_no_change: assert property (!exec |=>
        !done_reg && !fwr_reg.valid && !skip_reg
        && $stable(acc_reg) && $stable(status_reg))
        else $error("discarded or idle slot changed state");

    a_nop_one_cycle: assert property (exec && instr.op == CABO_NOP |=>
        done_reg && !skip_reg && !fwr_reg.valid
        && $stable(acc_reg) && $stable(status_reg))
        else $error("no-operation changed state");

endmodule

`default_nettype wire

// [include/cabo_pkg.sv]
// Package for the accumulator and bit-operation execution block of a small 8-bit core.
// Assumes one instruction clock; decoded operations arrive from a fetch/decode stage elsewhere.
package cabo_pkg;

    localparam int FILE_DEPTH = 128;
    localparam int FADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int HALF_CARRY_BIT = 4;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;
    localparam int SKIP_CYCLES = 2;

    typedef enum logic [2:0] {
        CABO_NOP,
        CABO_LITERAL_ADD_TO_ACC,
        CABO_FILE_ADD_TO_ACC,
        CABO_LITERAL_AND_TO_ACC,
        CABO_FILE_AND_TO_ACC,
        CABO_BIT_CLEAR_OP,
        CABO_BIT_SET_OP,
        CABO_BIT_TEST_SKIP_IF_ZERO
    } cabo_op_e;

    typedef struct packed {
        cabo_op_e op;
        logic [FADDR_W-1:0] faddr;
        logic dest;
        logic [2:0] bitsel;
        logic [DATA_W-1:0] literal;
    } cabo_instr_s;

    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
    } cabo_status_s;

    typedef struct packed {
        logic valid;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cabo_fwr_s;

    localparam cabo_status_s STATUS_RST = '{carry: 1'b0, half_carry_flag: 1'b0, zero: 1'b0};
    localparam cabo_fwr_s FWR_RST = '{valid: 1'b0, addr: 7'h00, data: 8'h00};

endpackage

// [sim/tb.sv]
// Self-checking bench for the accumulator and bit-operation block.
// Assumes the block's contract: one instruction taken per rising edge, results visible one cycle later.
`timescale 1ns/10ps
`default_nettype none

module tb;
    import cabo_pkg::*;
    logic core_clk;
    logic rst;
    logic instr_valid;
    cabo_instr_s instr;
    logic [7:0] acc_out;
    cabo_status_s status_out;
    cabo_fwr_s file_wr_out;
    logic op_done;
    logic nop_slot;
    logic [28:0] seen;
    int n_mismatch;
    int n_checks;

    // Accumulator, flags {c,h,z}, file write echo, op_done, nop_slot
    assign seen = {acc_out, status_out, file_wr_out, op_done, nop_slot};

    cabo_core i_cabo_core (
        .core_clk(core_clk),
        .rst(rst),
        .instr_valid(instr_valid),
        .instr(instr),
        .acc_out(acc_out),
        .status_out(status_out),
        .file_wr_out(file_wr_out),
        .op_done(op_done),
        .nop_slot(nop_slot)
    );

    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [28:0] got, input logic [28:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: outputs %h, expected %h", $time, got, exp);
        end
    endtask

    // Called at a falling edge; returns one cycle later with the results settled
    task automatic step(input cabo_op_e op, input logic [6:0] fa, input logic d, input logic [2:0] b,
                        input logic [7:0] k);
        instr_valid = 1'h1;
        instr = '{op: op, faddr: fa, dest: d, bitsel: b, literal: k};
        @(negedge core_clk);
    endtask

    task automatic t_lit_add();
        step(CABO_LITERAL_ADD_TO_ACC, 7'h00, 1'h0, 3'h0, 8'hFF);
        chk(seen, {8'hFF, 3'h0, 16'h0000, 2'h2});
        step(CABO_LITERAL_ADD_TO_ACC, 7'h00, 1'h0, 3'h0, 8'h01);
        chk(seen, {8'h00, 3'h7, 16'h0000, 2'h2});
        step(CABO_LITERAL_ADD_TO_ACC, 7'h00, 1'h0, 3'h0, 8'h3C);
        chk(seen, {8'h3C, 3'h0, 16'h0000, 2'h2});
        step(CABO_LITERAL_ADD_TO_ACC, 7'h00, 1'h0, 3'h0, 8'hCF);
        chk(seen, {8'h0B, 3'h6, 16'h0000, 2'h2});
    endtask

    // Carry and half carry are set beforehand so that a stray update shows
    task automatic t_lit_and();
        step(CABO_LITERAL_AND_TO_ACC, 7'h00, 1'h0, 3'h0, 8'h0B);
        chk(seen, {8'h0B, 3'h6, 16'h0000, 2'h2});
        step(CABO_LITERAL_AND_TO_ACC, 7'h00, 1'h0, 3'h0, 8'hF0);
        chk(seen, {8'h00, 3'h7, 16'h0000, 2'h2});
    endtask

    // Top file address; each op after the first reads back the byte the previous one wrote
    task automatic t_bits();
        step(CABO_BIT_SET_OP, 7'h7F, 1'h0, 3'h7, 8'h00);
        chk(seen, {8'h00, 3'h7, 16'hFF80, 2'h2});
        step(CABO_BIT_SET_OP, 7'h7F, 1'h0, 3'h0, 8'h00);
        chk(seen, {8'h00, 3'h7, 16'hFF81, 2'h2});
        step(CABO_BIT_CLEAR_OP, 7'h7F, 1'h0, 3'h7, 8'h00);
        chk(seen, {8'h00, 3'h7, 16'hFF01, 2'h2});
    endtask

    task automatic t_file_ops();
        step(CABO_LITERAL_ADD_TO_ACC, 7'h00, 1'h0, 3'h0, 8'h81);
        chk(seen, {8'h81, 3'h0, 16'h0000, 2'h2});
        step(CABO_FILE_ADD_TO_ACC, 7'h7F, DEST_FILE, 3'h0, 8'h00);
        chk(seen, {8'h81, 3'h0, 16'hFF82, 2'h2});
        step(CABO_FILE_ADD_TO_ACC, 7'h7F, DEST_ACC, 3'h0, 8'h00);
        chk(seen, {8'h03, 3'h4, 16'h7F00, 2'h2});
        step(CABO_FILE_AND_TO_ACC, 7'h7F, DEST_FILE, 3'h0, 8'h00);
        chk(seen, {8'h03, 3'h4, 16'hFF02, 2'h2});
        step(CABO_FILE_AND_TO_ACC, 7'h7F, DEST_ACC, 3'h0, 8'h00);
        chk(seen, {8'h02, 3'h4, 16'h7F00, 2'h2});
    endtask

    // File byte 7F holds 02: bit 1 set, bit 0 clear
    task automatic t_skip();
        step(CABO_BIT_TEST_SKIP_IF_ZERO, 7'h7F, 1'h0, 3'h1, 8'h00);
        chk(seen, {8'h02, 3'h4, 16'h7F00, 2'h2});
        step(CABO_LITERAL_ADD_TO_ACC, 7'h00, 1'h0, 3'h0, 8'h01);
        chk(seen, {8'h03, 3'h0, 16'h0000, 2'h2});
        step(CABO_BIT_TEST_SKIP_IF_ZERO, 7'h7F, 1'h0, 3'h0, 8'h00);
        chk(seen, {8'h03, 3'h0, 16'h7F00, 2'h3});
        step(CABO_LITERAL_ADD_TO_ACC, 7'h00, 1'h0, 3'h0, 8'h05);
        chk(seen, {8'h03, 3'h0, 16'h0000, 2'h0});
        step(CABO_LITERAL_ADD_TO_ACC, 7'h00, 1'h0, 3'h0, 8'h05);
        chk(seen, {8'h08, 3'h0, 16'h0000, 2'h2});
        step(CABO_NOP, 7'h00, 1'h0, 3'h0, 8'h00);
        chk(seen, {8'h08, 3'h0, 16'h0000, 2'h2});
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        n_mismatch = 0;
        n_checks = 0;
        rst = 1'h1;
        instr_valid = 1'h0;
        instr = '0;
        repeat (10) @(negedge core_clk);
        rst = 1'h0;
        @(negedge core_clk);
        chk(seen, {8'h00, 3'h0, 16'h0000, 2'h0});
        t_lit_add();
        t_lit_and();
        t_bits();
        t_file_ops();
        t_skip();
        instr_valid = 1'h0;
        @(negedge core_clk);
        summarize();
    end
endmodule

`default_nettype wire
